/* File: pkg/hbs_pkg.sv */
// Constants, field positions and carrier types of the host byte order stage
package hbs_pkg;

    // APB register byte offsets and address width
    localparam logic [7:0]  HBS_OFF_CFG      = 8'h00;
    localparam logic [7:0]  HBS_OFF_SWAP     = 8'h04;
    localparam logic [7:0]  HBS_OFF_STATUS   = 8'h08;
    localparam int          HBS_ADDR_W       = 8;

    // Field positions in the configuration register
    localparam int          HBS_CFG_PORT_BE  = 0;
    localparam int          HBS_CFG_SEL_BE   = 1;

    // Field positions in the status register
    localparam int          HBS_ST_WR_HALF   = 0;
    localparam int          HBS_ST_RD_HALF   = 1;
    localparam int          HBS_ST_SWAP_ON   = 2;

    // Reset values and the swap enable value
    localparam logic [1:0]  HBS_CFG_RST      = 2'h0;
    localparam logic [31:0] HBS_SWAP_RST     = 32'h0000_0000;
    localparam logic [31:0] HBS_SWAP_ENABLE  = 32'hFFFF_FFFF;

    // Kind of target a host access reaches
    typedef enum logic [1:0] {
        HBS_TGT_CSR,
        HBS_TGT_PORT_FIFO,
        HBS_TGT_SEL_FIFO,
        HBS_TGT_STATUS_FIFO
    } hbs_target_t;

    // One 16-bit host access
    typedef struct packed {
        logic        valid;                 // One-cycle access strobe
        logic        write;                 // High for a write
        logic        half_select_addr_bit;  // High selects the upper half
        hbs_target_t target;                // Which resource is reached
        logic [15:0] wdata;                 // Write half
    } hbs_host_req_t;

    // One internal 32-bit word transfer
    typedef struct packed {
        logic        valid;                 // One-cycle strobe
        hbs_target_t target;                // Which resource is reached
        logic [31:0] data;                  // Word in internal order
    } hbs_word_t;

endpackage

/* File: rtl/hbs_byte_order.sv */
// Host byte order stage: word swap and endian reversal with APB control
`timescale 1ns/100ps
module hbs_byte_order
    import hbs_pkg::*;
(
    input  wire logic                  mclk,            // 125 MHz clock
    input  wire logic                  rst,             // Async reset, active high
    // APB slave
    input  wire logic                  psel,            // Slave select
    input  wire logic                  penable,         // Access phase
    input  wire logic                  pwrite,          // Write direction
    input  wire logic [HBS_ADDR_W-1:0] paddr,           // Byte address
    input  wire logic [31:0]           pwdata,          // Write data
    output logic                       pready,          // Always ready
    output logic [31:0]                prdata,          // Read data
    output logic                       pslverr,         // Unmapped address
    // Host 16-bit side
    input  hbs_host_req_t              host_req,        // Half access
    output logic [15:0]                host_rdata,      // Read half
    output logic                       host_rvalid,     // Read half valid
    // Internal 32-bit side
    output hbs_word_t                  int_wr,          // Assembled write word
    input  wire logic [31:0]           int_rd_data,     // Word being read
    output logic                       int_rd_pop       // Read word consumed
);

    // Internal order to bus view {upper half, lower half} on reads
    function automatic logic [31:0] hbs_to_bus(
        input logic [31:0] w,
        input logic        rev,
        input logic        swp
    );
        logic [31:0] t;
        // Endian reversal first, then word swap
        t = rev ? {w[7:0], w[15:8], w[23:16], w[31:24]} : w;
        return swp ? {t[15:0], t[31:16]} : t;
    endfunction

    // Bus view to internal order on writes
    function automatic logic [31:0] hbs_to_int(
        input logic [31:0] b,
        input logic        rev,
        input logic        swp
    );
        logic [31:0] t;
        // Word swap first, then endian reversal
        t = swp ? {b[15:0], b[31:16]} : b;
        return rev ? {t[7:0], t[15:8], t[23:16], t[31:24]} : t;
    endfunction

    // Control state
    logic [1:0]  cfg;                 // Endian select bits
    logic [31:0] swap_reg;            // Word swap register
    logic [1:0]  next_cfg;
    logic [31:0] next_swap_reg;

    // Write pairing state
    logic        wr_have;             // One half held
    logic        wr_hold_hi;          // Held half is upper
    logic [15:0] wr_hold;             // Held half data
    logic        next_wr_have;
    logic        next_wr_hold_hi;
    logic [15:0] next_wr_hold;
    hbs_word_t   next_int_wr;

    // Read pairing state
    logic        rd_have;             // One half already read
    logic        rd_hold_hi;          // Which half was read
    logic        next_rd_have;
    logic        next_rd_hold_hi;
    logic [15:0] next_host_rdata;
    logic        next_host_rvalid;
    logic        next_int_rd_pop;

    // APB read data
    logic [31:0] next_prdata;

    // Decoded controls
    logic        swap_on;             // Word swap active
    logic        rev_on;              // Endian reversal for this access
    logic        apb_wr;              // APB write completes
    logic        apb_rd;              // APB read in setup phase
    logic        addr_ok;             // Mapped address

    // Swap only on the exact all-ones value
    assign swap_on = (swap_reg == HBS_SWAP_ENABLE);

    // Endian select per target
    always_comb begin
        case (host_req.target)
            HBS_TGT_PORT_FIFO: begin
                rev_on = cfg[HBS_CFG_PORT_BE];
            end
            HBS_TGT_SEL_FIFO: begin
                rev_on = cfg[HBS_CFG_SEL_BE];
            end
            default: begin
                rev_on = 1'b0;
            end
        endcase
    end

    // APB decode; zero wait states
    assign pready  = 1'b1;
    assign apb_wr  = psel && penable && pwrite;
    assign apb_rd  = psel && !penable && !pwrite;
    assign addr_ok = (paddr == HBS_OFF_CFG) || (paddr == HBS_OFF_SWAP)
                     || (paddr == HBS_OFF_STATUS);
    assign pslverr = psel && penable && !addr_ok;

    // Register writes and read data
    always_comb begin
        next_cfg      = cfg;
        next_swap_reg = swap_reg;
        next_prdata   = prdata;
        // Writes to mapped registers
        if (apb_wr) begin
            case (paddr)
                HBS_OFF_CFG: begin
                    next_cfg = {pwdata[HBS_CFG_SEL_BE], pwdata[HBS_CFG_PORT_BE]};
                end
                HBS_OFF_SWAP: begin
                    next_swap_reg = pwdata;
                end
                default: begin
                    next_cfg = cfg;
                end
            endcase
        end
        // Read data captured in setup, stands through access
        if (apb_rd) begin
            next_prdata = 32'h0000_0000;
            case (paddr)
                HBS_OFF_CFG: begin
                    next_prdata[HBS_CFG_PORT_BE] = cfg[HBS_CFG_PORT_BE];
                    next_prdata[HBS_CFG_SEL_BE]  = cfg[HBS_CFG_SEL_BE];
                end
                HBS_OFF_SWAP: begin
                    next_prdata = swap_reg;
                end
                HBS_OFF_STATUS: begin
                    next_prdata[HBS_ST_WR_HALF] = wr_have;
                    next_prdata[HBS_ST_RD_HALF] = rd_have;
                    next_prdata[HBS_ST_SWAP_ON] = swap_on;
                end
                default: begin
                    next_prdata = 32'h0000_0000;
                end
            endcase
        end
    end

    // Register stage for control state
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cfg      <= HBS_CFG_RST;
            swap_reg <= HBS_SWAP_RST;
            prdata   <= 32'h0000_0000;
        end else begin
            cfg      <= next_cfg;
            swap_reg <= next_swap_reg;
            prdata   <= next_prdata;
        end
    end

    // Write pairing: two halves of one word, either order
    always_comb begin
        logic [31:0] bus_w;
        bus_w           = 32'h0000_0000;
        next_wr_have    = wr_have;
        next_wr_hold_hi = wr_hold_hi;
        next_wr_hold    = wr_hold;
        next_int_wr     = '0;
        if (host_req.valid && host_req.write) begin
            if (!wr_have) begin
                // First half held
                next_wr_have    = 1'b1;
                next_wr_hold_hi = host_req.half_select_addr_bit;
                next_wr_hold    = host_req.wdata;
            end else if (host_req.half_select_addr_bit != wr_hold_hi) begin
                // Other half completes the word
                bus_w = host_req.half_select_addr_bit ?
                        {host_req.wdata, wr_hold} : {wr_hold, host_req.wdata};
                next_int_wr.valid  = 1'b1;
                next_int_wr.target = host_req.target;
                next_int_wr.data   = hbs_to_int(bus_w, rev_on, swap_on);
                next_wr_have       = 1'b0;
            end else begin
                // Same half twice: transfer disregarded
                next_wr_have = 1'b1;
            end
        end
    end

    // Register stage for write pairing
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wr_have    <= 1'b0;
            wr_hold_hi <= 1'b0;
            wr_hold    <= 16'h0000;
            int_wr     <= '0;
        end else begin
            wr_have    <= next_wr_have;
            wr_hold_hi <= next_wr_hold_hi;
            wr_hold    <= next_wr_hold;
            int_wr     <= next_int_wr;
        end
    end

    // Read path: each half taken from the current word
    always_comb begin
        logic [31:0] bus_r;
        bus_r            = hbs_to_bus(int_rd_data, rev_on, swap_on);
        next_rd_have     = rd_have;
        next_rd_hold_hi  = rd_hold_hi;
        next_host_rdata  = host_rdata;
        next_host_rvalid = 1'b0;
        next_int_rd_pop  = 1'b0;
        if (host_req.valid && !host_req.write) begin
            // Upper half on A1 high, lower on A1 low
            next_host_rdata  = host_req.half_select_addr_bit ?
                               bus_r[31:16] : bus_r[15:0];
            next_host_rvalid = 1'b1;
            if (rd_have && (host_req.half_select_addr_bit != rd_hold_hi)) begin
                // Pair done: word consumed
                next_rd_have    = 1'b0;
                next_int_rd_pop = 1'b1;
            end else begin
                // First half, or same half again restarts the pair
                next_rd_have    = 1'b1;
                next_rd_hold_hi = host_req.half_select_addr_bit;
            end
        end
    end

    // Register stage for read path
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rd_have     <= 1'b0;
            rd_hold_hi  <= 1'b0;
            host_rdata  <= 16'h0000;
            host_rvalid <= 1'b0;
            int_rd_pop  <= 1'b0;
        end else begin
            rd_have     <= next_rd_have;
            rd_hold_hi  <= next_rd_hold_hi;
            host_rdata  <= next_host_rdata;
            host_rvalid <= next_host_rvalid;
            int_rd_pop  <= next_int_rd_pop;
        end
    end

endmodule

/* File: sim/hbs_byte_order_assertions.sv */
// Checker of the host byte order stage ports
`timescale 1ns/100ps
module hbs_byte_order_chk
    import hbs_pkg::*;
(
    input wire logic     mclk,
    input wire logic     rst,
    input wire logic     psel,
    input wire logic     penable,
    input logic          pready,
    input logic          pslverr,
    input hbs_host_req_t host_req,
    input logic [15:0]   host_rdata,
    input logic          host_rvalid,
    input hbs_word_t     int_wr,
    input logic          int_rd_pop
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // Read and write strobes, upper half flag
    wire rd = host_req.valid && !host_req.write;
    wire wr = host_req.valid && host_req.write;
    wire hi = host_req.half_select_addr_bit;
    ready_const_a: assert property (pready) else $error("pready low");
    err_access_a: assert property (pslverr |-> psel && penable) else $error("stray pslverr");
    rd_answer_a: assert property (rd |=> host_rvalid) else $error("no read answer");
    rd_spur_a: assert property (!rd |=> !host_rvalid) else $error("stray rvalid");
    rd_hold_a: assert property (!host_rvalid |-> $stable(host_rdata)) else $error("rdata moved");
    pop_pair_a: assert property (rd && !hi ##1 rd && hi && !int_rd_pop |=> int_rd_pop)
        else $error("no pop after pair");
    wr_refuse_a: assert property (wr && hi ##1 wr && hi |=> !int_wr.valid)
        else $error("same half accepted");
    csr_order_a: assert property (wr && hi ##1 wr && !hi && !int_wr.valid
        && host_req.target == HBS_TGT_CSR
        |=> int_wr.valid && int_wr.target == HBS_TGT_CSR
        && (int_wr.data == {$past(host_req.wdata, 2), $past(host_req.wdata)}
        || int_wr.data == {$past(host_req.wdata), $past(host_req.wdata, 2)}))
        else $error("csr word order");
    cover property (int_wr.valid);
    cover property (int_rd_pop);
    cover property (pslverr);
endmodule
bind hbs_byte_order hbs_byte_order_chk hbs_byte_order_chk_i (.mclk(mclk), .rst(rst),
    .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
    .host_req(host_req), .host_rdata(host_rdata), .host_rvalid(host_rvalid),
    .int_wr(int_wr), .int_rd_pop(int_rd_pop));

/* File: sim/hbs_host_model.sv */
// Host processor model making paired 16-bit accesses
`timescale 1ns/100ps
module hbs_host_model
    import hbs_pkg::*;
(
    input wire logic        mclk,
    output hbs_host_req_t   req,
    input wire logic [15:0] host_rdata
);
    initial req = '0;
    // Two back-to-back halves, then idle with half select and write data inverted
    task automatic xfer(input logic wr, a1, a1b, hbs_target_t tg,
                        input logic [31:0] w, output logic [31:0] r);
        logic s;
        for (int i = 0; i < 3; i++) begin
            @(posedge mclk);
            s = (i == 0) ? a1 : a1b;
            if (i < 2) req <= '{1'b1, wr, s, tg, s ? w[31:16] : w[15:0]};
            else req <= '{1'b0, 1'b0, ~a1b, tg, ~req.wdata};
            if (i > 0) begin
                #1;
                s = (i == 1) ? a1 : a1b;
                if (s) r[31:16] = host_rdata;
                else r[15:0] = host_rdata;
            end
        end
    endtask
endmodule

/* File: sim/hbs_byte_order_tb.sv */
// Self-checking bench of the host byte order stage
`timescale 1ns/100ps
module hbs_byte_order_tb;
    import hbs_pkg::*;
    typedef struct packed {
        logic [31:0] swp;
        logic [1:0]  cfg;
        hbs_target_t tg;
        logic [31:0] exp;
    } hbs_row_t;
    localparam logic [31:0] W = 32'h3322_1100;
    // Status with both halves pending and swap active
    localparam logic [31:0] ST_PEND = (32'h1 << HBS_ST_WR_HALF) | (32'h1 << HBS_ST_RD_HALF)
                                      | (32'h1 << HBS_ST_SWAP_ON);
    logic mclk, rst, psel, penable, pwrite, pready, pslverr, host_rvalid, int_rd_pop, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, int_rd_data, rv;
    logic [15:0] host_rdata;
    hbs_host_req_t host_req;
    hbs_word_t     int_wr;
    int n_fail = 0;
    int checks_done = 0;
    // Swap value, endian bits, target, expected word for bus word W
    hbs_row_t rows [11] = '{
        '{32'h0, 2'h0, HBS_TGT_PORT_FIFO, W},
        '{32'h0, 2'h1, HBS_TGT_PORT_FIFO, 32'h0011_2233},
        '{32'h0, 2'h2, HBS_TGT_PORT_FIFO, W},
        '{32'h0, 2'h2, HBS_TGT_SEL_FIFO, 32'h0011_2233},
        '{32'h0, 2'h1, HBS_TGT_SEL_FIFO, W},
        '{32'hFFFF_FFFF, 2'h0, HBS_TGT_SEL_FIFO, 32'h1100_3322},
        '{32'hFFFF_FFFF, 2'h3, HBS_TGT_PORT_FIFO, 32'h2233_0011},
        '{32'hFFFF_FFFF, 2'h3, HBS_TGT_CSR, 32'h1100_3322},
        '{32'h0, 2'h3, HBS_TGT_STATUS_FIFO, W},
        '{32'hFFFF_FFFE, 2'h3, HBS_TGT_PORT_FIFO, 32'h0011_2233},
        '{32'hFFFF_FFFF, 2'h3, HBS_TGT_STATUS_FIFO, 32'h1100_3322}};
    hbs_byte_order hbs_byte_order_i (.mclk(mclk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .host_req(host_req),
        .host_rdata(host_rdata), .host_rvalid(host_rvalid), .int_wr(int_wr),
        .int_rd_data(int_rd_data), .int_rd_pop(int_rd_pop));
    hbs_host_model hbs_host_model_i (.mclk(mclk), .req(host_req), .host_rdata(host_rdata));
    // Clock of 8 ns
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    // Compare and count
    task automatic chk(input logic [31:0] seen, exp, input string nm);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // One APB transfer, waits for pready under a bound
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge mclk);
            if (pready === 1'b1) break;
        end
        if (n == 20) begin
            n_fail++;
            final_report();
        end
        rv = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        int_rd_data = W;
        rst = 1'b1;
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        foreach (rows[k]) begin
            apb(1'b1, HBS_OFF_CFG, {30'h0, rows[k].cfg});
            apb(1'b1, HBS_OFF_SWAP, rows[k].swp);
            apb(1'b0, HBS_OFF_SWAP, 32'h0);
            chk(rv, rows[k].swp, "swap reg");
            apb(1'b0, HBS_OFF_CFG, 32'h0);
            chk(rv, {30'h0, rows[k].cfg}, "cfg reg");
            apb(1'b0, HBS_OFF_STATUS, 32'h0);
            chk(rv, 32'(rows[k].swp == HBS_SWAP_ENABLE) << HBS_ST_SWAP_ON, "status");
            hbs_host_model_i.xfer(1'b1, 1'b1, 1'b0, rows[k].tg, W, rv);
            chk(int_wr.valid, 1'b1, "wr valid");
            chk(int_wr.data, rows[k].exp, "wr data");
            hbs_host_model_i.xfer(1'b0, 1'b0, 1'b1, rows[k].tg, W, rv);
            chk(rv, rows[k].exp, "rd data");
            chk(int_rd_pop, 1'b1, "rd pop");
            $display("row %0d done", k);
        end
        apb(1'b0, 8'h0C, 32'h0);
        chk(rv, 32'h0, "unmapped data");
        chk(err, 1'b1, "unmapped err");
        $display("unmapped done");
        // Same half twice: write dropped, read restarts
        hbs_host_model_i.xfer(1'b1, 1'b1, 1'b1, HBS_TGT_CSR, W, rv);
        chk(int_wr.valid, 1'b0, "dup write");
        hbs_host_model_i.xfer(1'b0, 1'b0, 1'b0, HBS_TGT_CSR, W, rv);
        chk(int_rd_pop, 1'b0, "dup read");
        // Both halves left pending, swap still on
        apb(1'b0, HBS_OFF_STATUS, 32'h0);
        chk(rv, ST_PEND, "status pending");
        $display("same half done");
        // Mid-run reset held two edges returns defaults
        @(posedge mclk) rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        apb(1'b0, HBS_OFF_SWAP, 32'h0);
        chk(rv, HBS_SWAP_RST, "swap reset");
        apb(1'b0, HBS_OFF_CFG, 32'h0);
        chk(rv, {30'h0, HBS_CFG_RST}, "cfg reset");
        apb(1'b0, HBS_OFF_STATUS, 32'h0);
        chk(rv, 32'h0, "status reset");
        $display("reset done");
        final_report();
    end
endmodule
